// ### hdl/wf_cfg.svh
/*
 * Constants of the field bitstream framer: counts, delimiter variants
 * and the fixed word that opens every first block sequence.
 * Assumes the includer also compiles wf_pkg for the token types.
 */
// Overview of operation
// - Stream alternates field one then field two.
// - Decode supplier appends sequence end marker last.
// - Field: delimiter, time code, first, complete blocks.
// - First block: type word, bin width, payload.
// - Complete block sequence holds exactly 41 blocks.
// - Block: delimiter, bin width, then payload.
// - Only block delimiter variants one to five.
// - First block payload is wavelet block six.
// - Variant five marks a zero data block.
`ifndef WF_CFG_SVH
`define WF_CFG_SVH

// Blocks following the first block in every field
`define WF_BLOCKS 6'h29
`define WF_BLK_ZERO 6'h00
`define WF_VAR_MIN 3'h1
`define WF_VAR_ZERO 3'h5
`define WF_VAR_NONE 3'h0
// Wavelet block carried by the first block sequence
`define WF_FIRST_BLOCK_NUM 6'h06
// Encoding of the type word is arbitrary here
`define WF_TYPE_WORD 32'h0000_0004
`define WF_DATA_ZERO 32'h0000_0000

`endif

// ### hdl/wf_dev_end.sv
/*
 * Codec end: parses and checks the decode stream arriving from the
 * host, and frames the encode stream sent to the host.
 * Assumes the host end drives the h2d channel by the same token rules.
 */
`timescale 1ns/1ps
`include "wf_cfg.svh"
module wf_dev_end (
  input wire logic core_clk,
  input wire logic rstn,
  wf_link_if.dev link,
  input wire logic enc_valid,
  output logic enc_ready,
  input wire logic [31:0] enc_data,
  input wire logic enc_last,
  input wire logic enc_zero,
  input wire logic [2:0] enc_var,
  input wire logic enc_end,
  output logic dec_valid,
  output wf_pkg::wf_tok_t dec_tok,
  output logic [5:0] dec_blk,
  output logic dec_err,
  output logic dec_done
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wf_pkg::wf_pst_t p_st;
    logic p_f2;
    logic p_zero;
    logic [5:0] p_blk;
    logic ud_valid;
    wf_pkg::wf_tok_t ud_tok;
    logic [5:0] ud_blk;
    logic err;
    logic done;
    wf_pkg::wf_fst_t f_st;
    logic f_f2;
    logic f_zero;
    logic [5:0] f_blk;
    logic o_valid;
    wf_pkg::wf_tok_t o_tok;
  } wf_dev_st_t;

  wf_dev_st_t st_q;
  wf_dev_st_t st_d;
  wf_pkg::wf_tok_t t;
  logic is_field;
  logic is_hdr;
  logic bad;

  assign t = link.h2d_tok;
  assign is_field = (t.kind == wf_pkg::WF_FIELD_ONE) ||
                    (t.kind == wf_pkg::WF_FIELD_TWO);

  // ****************************************
  // Next state
  // ****************************************
  always_comb begin
    st_d = st_q;
    enc_ready = 1'b0;
    is_hdr = 1'b0;
    bad = 1'b0;
    st_d.ud_valid = 1'b0;
    st_d.err = 1'b0;
    st_d.done = 1'b0;
    // Parser: every token is taken, so the host is never stalled
    if (link.h2d_valid) begin
      st_d.ud_valid = 1'b1;
      st_d.ud_tok = t;
      // count zero marks wavelet block six
      st_d.ud_blk = st_q.p_blk;
      case (st_q.p_st)
        wf_pkg::WF_P_HDR: begin
          is_hdr = 1'b1;
        end
        wf_pkg::WF_P_TC: begin
          bad = t.kind != wf_pkg::WF_TIME_CODE;
          st_d.p_st = wf_pkg::WF_P_TYPE;
        end
        wf_pkg::WF_P_TYPE: begin
          bad = t.kind != wf_pkg::WF_TYPE;
          st_d.p_st = wf_pkg::WF_P_FBW;
        end
        wf_pkg::WF_P_FBW: begin
          bad = t.kind != wf_pkg::WF_BIN_WIDTH;
          st_d.p_st = wf_pkg::WF_P_PAY;
        end
        wf_pkg::WF_P_BBW: begin
          bad = t.kind != wf_pkg::WF_BIN_WIDTH;
          st_d.p_st = wf_pkg::WF_P_PAY;
        end
        wf_pkg::WF_P_PAY: begin
          if (t.kind == wf_pkg::WF_PAYLOAD) begin
            bad = st_q.p_zero;
          end else if (t.kind == wf_pkg::WF_BLOCK_START) begin
            bad = (t.variant < `WF_VAR_MIN) ||
                  (t.variant > `WF_VAR_ZERO) ||
                  (st_q.p_blk == `WF_BLOCKS);
            st_d.p_blk = st_q.p_blk + 6'h01;
            st_d.p_zero = t.variant == `WF_VAR_ZERO;
            st_d.p_st = wf_pkg::WF_P_BBW;
          end else if (is_field ||
                       t.kind == wf_pkg::WF_SEQ_END) begin
            // field must hold all 41 blocks
            bad = st_q.p_blk != `WF_BLOCKS;
            st_d.p_f2 = ~st_q.p_f2;
            is_hdr = 1'b1;
          end else begin
            bad = 1'b1;
          end
        end
        default: begin
          st_d.p_st = wf_pkg::WF_P_HDR;
        end
      endcase
      if (is_hdr) begin
        st_d.p_blk = `WF_BLK_ZERO;
        st_d.p_zero = 1'b0;
        st_d.p_st = wf_pkg::WF_P_HDR;
        if (is_field) begin
          bad = bad ||
                ((t.kind == wf_pkg::WF_FIELD_TWO) != st_d.p_f2);
          // Resynchronise on the field actually received
          st_d.p_f2 = t.kind == wf_pkg::WF_FIELD_TWO;
          st_d.p_st = wf_pkg::WF_P_TC;
        end else if (t.kind == wf_pkg::WF_SEQ_END) begin
          // end marker closes the sequence after field two
          bad = bad || st_d.p_f2;
          st_d.done = 1'b1;
          st_d.p_f2 = 1'b0;
        end else begin
          bad = 1'b1;
        end
      end
      // framing error reported, hunt for next header
      if (bad) begin
        st_d.err = 1'b1;
        if (!is_hdr) begin
          st_d.p_st = wf_pkg::WF_P_HDR;
        end
      end
    end
    // Framer: single output register, refilled when empty or in the cycle it drains
    if (st_q.o_valid && link.d2h_ready) begin
      st_d.o_valid = 1'b0;
    end
    if ((!st_q.o_valid || link.d2h_ready) && enc_valid) begin
      st_d.o_valid = 1'b1;
      st_d.o_tok = '{wf_pkg::WF_PAYLOAD, `WF_VAR_NONE, enc_data};
      case (st_q.f_st)
        wf_pkg::WF_F_IDLE: begin
          if (enc_end) begin
            st_d.o_tok.kind = wf_pkg::WF_SEQ_END;
            st_d.f_f2 = 1'b0;
            enc_ready = 1'b1;
          end else begin
            st_d.o_tok.kind = st_q.f_f2 ? wf_pkg::WF_FIELD_TWO :
                                          wf_pkg::WF_FIELD_ONE;
            st_d.f_st = wf_pkg::WF_F_TC;
          end
        end
        wf_pkg::WF_F_TC: begin
          st_d.o_tok.kind = wf_pkg::WF_TIME_CODE;
          enc_ready = 1'b1;
          st_d.f_st = wf_pkg::WF_F_TYPE;
        end
        wf_pkg::WF_F_TYPE: begin
          // type word without a block delimiter
          st_d.o_tok.kind = wf_pkg::WF_TYPE;
          st_d.o_tok.data = `WF_TYPE_WORD;
          st_d.f_st = wf_pkg::WF_F_FBW;
        end
        wf_pkg::WF_F_FBW: begin
          st_d.o_tok.kind = wf_pkg::WF_BIN_WIDTH;
          enc_ready = 1'b1;
          st_d.f_blk = `WF_BLK_ZERO;
          st_d.f_st = wf_pkg::WF_F_PAY;
        end
        wf_pkg::WF_F_PAY: begin
          enc_ready = 1'b1;
          if (enc_last) begin
            if (st_q.f_blk == `WF_BLOCKS) begin
              st_d.f_f2 = ~st_q.f_f2;
              st_d.f_st = wf_pkg::WF_F_IDLE;
            end else begin
              st_d.f_st = wf_pkg::WF_F_SOB;
            end
          end
        end
        wf_pkg::WF_F_SOB: begin
          st_d.o_tok.kind = wf_pkg::WF_BLOCK_START;
          st_d.o_tok.data = `WF_DATA_ZERO;
          st_d.f_zero = enc_zero ||
                        enc_var < `WF_VAR_MIN ||
                        enc_var > `WF_VAR_ZERO;
          st_d.o_tok.variant = st_d.f_zero ? `WF_VAR_ZERO : enc_var;
          st_d.f_blk = st_q.f_blk + 6'h01;
          st_d.f_st = wf_pkg::WF_F_BBW;
        end
        wf_pkg::WF_F_BBW: begin
          st_d.o_tok.kind = wf_pkg::WF_BIN_WIDTH;
          enc_ready = 1'b1;
          if (!st_q.f_zero) begin
            st_d.f_st = wf_pkg::WF_F_PAY;
          end else if (st_q.f_blk == `WF_BLOCKS) begin
            st_d.f_f2 = ~st_q.f_f2;
            st_d.f_st = wf_pkg::WF_F_IDLE;
          end else begin
            st_d.f_st = wf_pkg::WF_F_SOB;
          end
        end
        default: begin
          st_d.o_valid = 1'b0;
          st_d.f_st = wf_pkg::WF_F_IDLE;
        end
      endcase
    end
  end

  // ****************************************
  // Registers
  // ****************************************
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign link.h2d_ready = 1'b1;
  assign link.d2h_valid = st_q.o_valid;
  assign link.d2h_tok = st_q.o_tok;
  assign dec_valid = st_q.ud_valid;
  assign dec_tok = st_q.ud_tok;
  assign dec_blk = st_q.ud_blk;
  assign dec_err = st_q.err;
  assign dec_done = st_q.done;

endmodule // wf_dev_end

// ### hdl/wf_host_end.sv
/*
 * Host end: frames the decode stream sent to the codec and hands the
 * encode stream from the codec to the host user side.
 * Assumes the codec end keeps the same token rules.
 */
`timescale 1ns/1ps
`include "wf_cfg.svh"
module wf_host_end (
  input wire logic core_clk,
  input wire logic rstn,
  wf_link_if.host link,
  input wire logic src_valid,
  output logic src_ready,
  input wire logic [31:0] src_data,
  input wire logic src_last,
  input wire logic src_zero,
  input wire logic [2:0] src_var,
  input wire logic src_end,
  output logic snk_valid,
  input wire logic snk_ready,
  output wf_pkg::wf_tok_t snk_tok
);

  // ****************************************
  // State
  // ****************************************
  typedef struct packed {
    wf_pkg::wf_fst_t f_st;
    logic f_f2;
    logic f_zero;
    logic [5:0] f_blk;
    logic o_valid;
    wf_pkg::wf_tok_t o_tok;
  } wf_host_st_t;

  wf_host_st_t st_q;
  wf_host_st_t st_d;

  always_comb begin
    st_d = st_q;
    src_ready = 1'b0;
    if (st_q.o_valid && link.h2d_ready) begin
      st_d.o_valid = 1'b0;
    end
    if ((!st_q.o_valid || link.h2d_ready) && src_valid) begin
      st_d.o_valid = 1'b1;
      st_d.o_tok = '{wf_pkg::WF_PAYLOAD, `WF_VAR_NONE, src_data};
      case (st_q.f_st)
        wf_pkg::WF_F_IDLE: begin
          if (src_end) begin
            st_d.o_tok.kind = wf_pkg::WF_SEQ_END;
            st_d.f_f2 = 1'b0;
            src_ready = 1'b1;
          end else begin
            st_d.o_tok.kind = st_q.f_f2 ? wf_pkg::WF_FIELD_TWO :
                                          wf_pkg::WF_FIELD_ONE;
            st_d.f_st = wf_pkg::WF_F_TC;
          end
        end
        wf_pkg::WF_F_TC: begin
          st_d.o_tok.kind = wf_pkg::WF_TIME_CODE;
          src_ready = 1'b1;
          st_d.f_st = wf_pkg::WF_F_TYPE;
        end
        wf_pkg::WF_F_TYPE: begin
          st_d.o_tok.kind = wf_pkg::WF_TYPE;
          st_d.o_tok.data = `WF_TYPE_WORD;
          st_d.f_st = wf_pkg::WF_F_FBW;
        end
        wf_pkg::WF_F_FBW: begin
          st_d.o_tok.kind = wf_pkg::WF_BIN_WIDTH;
          src_ready = 1'b1;
          st_d.f_blk = `WF_BLK_ZERO;
          st_d.f_st = wf_pkg::WF_F_PAY;
        end
        wf_pkg::WF_F_PAY: begin
          src_ready = 1'b1;
          if (src_last) begin
            if (st_q.f_blk == `WF_BLOCKS) begin
              st_d.f_f2 = ~st_q.f_f2;
              st_d.f_st = wf_pkg::WF_F_IDLE;
            end else begin
              st_d.f_st = wf_pkg::WF_F_SOB;
            end
          end
        end
        wf_pkg::WF_F_SOB: begin
          st_d.o_tok.kind = wf_pkg::WF_BLOCK_START;
          st_d.o_tok.data = `WF_DATA_ZERO;
          st_d.f_zero = src_zero ||
                        src_var < `WF_VAR_MIN ||
                        src_var > `WF_VAR_ZERO;
          st_d.o_tok.variant = st_d.f_zero ? `WF_VAR_ZERO : src_var;
          st_d.f_blk = st_q.f_blk + 6'h01;
          st_d.f_st = wf_pkg::WF_F_BBW;
        end
        wf_pkg::WF_F_BBW: begin
          st_d.o_tok.kind = wf_pkg::WF_BIN_WIDTH;
          src_ready = 1'b1;
          if (!st_q.f_zero) begin
            st_d.f_st = wf_pkg::WF_F_PAY;
          end else if (st_q.f_blk == `WF_BLOCKS) begin
            st_d.f_f2 = ~st_q.f_f2;
            st_d.f_st = wf_pkg::WF_F_IDLE;
          end else begin
            st_d.f_st = wf_pkg::WF_F_SOB;
          end
        end
        default: begin
          st_d.o_valid = 1'b0;
          st_d.f_st = wf_pkg::WF_F_IDLE;
        end
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // Encode stream is passed straight through; the sink stalls the codec
  assign link.h2d_valid = st_q.o_valid;
  assign link.h2d_tok = st_q.o_tok;
  assign link.d2h_ready = snk_ready;
  assign snk_valid = link.d2h_valid;
  assign snk_tok = link.d2h_tok;

endmodule // wf_host_end

// ### hdl/wf_link_if.sv
/*
 * Link between the codec end and the host end: one token channel
 * toward the codec (decode) and one toward the host (encode).
 * Assumes both ends share core_clk and rstn.
 */
`timescale 1ns/1ps
interface wf_link_if (
  input wire logic core_clk,
  input wire logic rstn
);
  logic h2d_valid;
  logic h2d_ready;
  wf_pkg::wf_tok_t h2d_tok;
  logic d2h_valid;
  logic d2h_ready;
  wf_pkg::wf_tok_t d2h_tok;

  modport dev (
    input h2d_valid, h2d_tok, d2h_ready,
    output h2d_ready, d2h_valid, d2h_tok
  );
  modport host (
    output h2d_valid, h2d_tok, d2h_ready,
    input h2d_ready, d2h_valid, d2h_tok
  );
endinterface // wf_link_if

// ### hdl/wf_pkg.sv
/*
 * Types shared by both ends of the field bitstream link.
 * Assumes nothing beyond a SystemVerilog compiler.
 */
package wf_pkg;

  // ****************************************
  // Token kinds on the link
  // ****************************************
  typedef enum logic [2:0] {
    WF_FIELD_ONE = 3'b000,
    WF_FIELD_TWO = 3'b001,
    WF_TIME_CODE = 3'b010,
    WF_TYPE = 3'b011,
    WF_BIN_WIDTH = 3'b100,
    WF_PAYLOAD = 3'b101,
    WF_BLOCK_START = 3'b110,
    WF_SEQ_END = 3'b111
  } wf_kind_t;

  typedef struct packed {
    wf_kind_t kind;
    logic [2:0] variant;
    logic [31:0] data;
  } wf_tok_t;

  // ****************************************
  // Framer states
  // ****************************************
  typedef enum logic [2:0] {
    WF_F_IDLE = 3'b000,
    WF_F_TC = 3'b001,
    WF_F_TYPE = 3'b010,
    WF_F_FBW = 3'b011,
    WF_F_PAY = 3'b100,
    WF_F_SOB = 3'b101,
    WF_F_BBW = 3'b110
  } wf_fst_t;

  // ****************************************
  // Parser states
  // ****************************************
  typedef enum logic [2:0] {
    WF_P_HDR = 3'b000,
    WF_P_TC = 3'b001,
    WF_P_TYPE = 3'b010,
    WF_P_FBW = 3'b011,
    WF_P_PAY = 3'b100,
    WF_P_BBW = 3'b101
  } wf_pst_t;

endpackage

// ### test/wavelet_field_bitstream_framer_bench.sv
/* Bench: both ends joined in both directions, plus a spare codec end
   fed broken streams. Assumes design files and checker compile first. */
`timescale 1ns/1ps
`include "wf_cfg.svh"
module automatic wavelet_field_bitstream_framer_bench;
  logic core_clk = 1'h0;
  logic rstn = 1'h0;
  logic rst2n = 1'h0;
  logic snk_ready = 1'h1;
  logic [38:0] u [2] = '{39'h0, 39'h0};
  logic dec_valid, dec_err, dec_done, err2, snk_valid;
  logic src_ready, enc_ready;
  wf_pkg::wf_tok_t dec_tok, snk_tok;
  logic [5:0] dec_blk;
  wf_pkg::wf_tok_t exq [2][$];
  int num_errors = 0;
  int n_checks = 0;
  int n_done = 0;
  int n_err = 0;
  int n_err2 = 0;
  wf_link_if i_wf_link_if (.core_clk(core_clk), .rstn(rstn));
  wf_link_if i_wf_link_if_b (.core_clk(core_clk), .rstn(rst2n));
  wf_dev_end i_wf_dev_end (.core_clk(core_clk), .rstn(rstn),
    .link(i_wf_link_if), .enc_valid(u[1][38]), .enc_ready(enc_ready),
    .enc_data(u[1][31:0]), .enc_last(u[1][37]), .enc_zero(u[1][36]),
    .enc_var(u[1][35:33]), .enc_end(u[1][32]), .dec_valid(dec_valid),
    .dec_tok(dec_tok), .dec_blk(dec_blk), .dec_err(dec_err),
    .dec_done(dec_done));
  wf_host_end i_wf_host_end (.core_clk(core_clk), .rstn(rstn),
    .link(i_wf_link_if), .src_valid(u[0][38]), .src_ready(src_ready),
    .src_data(u[0][31:0]), .src_last(u[0][37]), .src_zero(u[0][36]),
    .src_var(u[0][35:33]), .src_end(u[0][32]), .snk_valid(snk_valid),
    .snk_ready(snk_ready), .snk_tok(snk_tok));
  // Spare codec end: only its framing error pulse is judged
  wf_dev_end i_wf_dev_end_b (.core_clk(core_clk), .rstn(rst2n),
    .link(i_wf_link_if_b), .enc_valid(1'h0), .enc_ready(),
    .enc_data(u[1][31:0]), .enc_last(1'h0), .enc_zero(1'h0), .enc_var(3'h0),
    .enc_end(1'h0), .dec_valid(), .dec_tok(), .dec_blk(), .dec_err(err2),
    .dec_done());
  wf_link_properties u_chk (.core_clk(core_clk), .rstn(rstn),
    .h2d_valid(i_wf_link_if.h2d_valid), .h2d_ready(i_wf_link_if.h2d_ready),
    .h2d_tok(i_wf_link_if.h2d_tok), .d2h_valid(i_wf_link_if.d2h_valid),
    .d2h_ready(i_wf_link_if.d2h_ready), .d2h_tok(i_wf_link_if.d2h_tok));
  initial begin
    forever #4 core_clk = ~core_clk;
  end
  // One cycle in five the host sink stalls the codec framer
  always @(posedge core_clk) #1 snk_ready = ($time % 40) > 10;
  // ****************************************
  // Tasks
  // ****************************************
  task wrap_up();
    $display("checks %0d errors %0d", n_checks, num_errors);
    if (num_errors == 0 && n_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask
  task fail(input string m);
    num_errors++;
    $display("[ERR] %0t %s", $time, m);
  endtask
  task chk(input int s, input wf_pkg::wf_tok_t t);
    wf_pkg::wf_tok_t e;
    n_checks++;
    if (exq[s].size() == 0) fail("unexpected token");
    else begin
      e = exq[s].pop_front();
      if (t.kind !== e.kind || (e.kind == wf_pkg::WF_BLOCK_START &&
          t.variant !== e.variant) || (t.data !== e.data && e.kind inside
          {[wf_pkg::WF_TIME_CODE:wf_pkg::WF_PAYLOAD]}))
        fail("token mismatch");
    end
  endtask
  task push(input int s, input wf_pkg::wf_kind_t k, input logic [2:0] v,
      input logic [31:0] d);
    exq[s].push_back({k, v, d});
  endtask
  // Word stays presented until the framer's ready is seen at an edge
  task put(input int s, input logic l, input logic z, input logic [2:0] v,
      input logic e, input logic [31:0] d);
    int k;
    u[s] = {1'h1, l, z, v, e, d};
    k = 0;
    do begin
      @(posedge core_clk);
      k++;
    end while ((s ? enc_ready : src_ready) !== 1'h1 && k < 300);
    #1;
    if (k >= 300) begin
      fail("ready timeout");
      wrap_up();
    end
  endtask
  task fld(input int s, input logic f2);
    logic [2:0] v;
    push(s, wf_pkg::wf_kind_t'({2'h0, f2}), 3'h0, 32'h0);
    push(s, wf_pkg::WF_TIME_CODE, 3'h0, {31'h0, f2});
    push(s, wf_pkg::WF_TYPE, 3'h0, `WF_TYPE_WORD);
    push(s, wf_pkg::WF_BIN_WIDTH, 3'h0, 32'h1DDC);
    push(s, wf_pkg::WF_PAYLOAD, 3'h0, 32'hA0);
    push(s, wf_pkg::WF_PAYLOAD, 3'h0, 32'hA1);
    put(s, 1'h0, 1'h0, 3'h0, 1'h0, {31'h0, f2});
    put(s, 1'h0, 1'h0, 3'h0, 1'h0, 32'h1DDC);
    put(s, 1'h0, 1'h0, 3'h0, 1'h0, 32'hA0);
    put(s, 1'h1, 1'h0, 3'h0, 1'h0, 32'hA1);
    for (int i = 0; i < 41; i++) begin
      v = 3'(i % 5 + 1);
      push(s, wf_pkg::WF_BLOCK_START, v, 32'h0);
      push(s, wf_pkg::WF_BIN_WIDTH, 3'h0, 32'(i));
      // Late zero blocks use an out-of-range variant instead of the flag
      put(s, 1'h0, v == 3'h5 && i < 20, (v == 3'h5 && i >= 20) ? 3'h7 : v,
          1'h0, 32'(i));
      if (v != 3'h5) begin
        push(s, wf_pkg::WF_PAYLOAD, 3'h0, ~32'(i));
        put(s, 1'h1, 1'h0, v, 1'h0, ~32'(i));
      end
    end
  endtask
  task run(input int s);
    for (int f = 0; f < 4; f++) fld(s, f[0]);
    push(s, wf_pkg::WF_SEQ_END, 3'h0, 32'h0);
    put(s, 1'h0, 1'h0, 3'h0, 1'h1, 32'h0);
    u[s] = 39'h0;
  endtask
  task raw(input wf_pkg::wf_kind_t k, input logic [2:0] v);
    i_wf_link_if_b.h2d_tok = {k, v,
      k == wf_pkg::WF_TYPE ? `WF_TYPE_WORD : 32'h0};
    i_wf_link_if_b.h2d_valid = 1'h1;
    @(posedge core_clk);
    #1;
  endtask
  task err_case(input int nb, input logic [2:0] v, input logic p,
      input logic t, input logic x);
    rst2n = 1'h0;
    @(posedge core_clk);
    #1 rst2n = 1'h1;
    n_err2 = 0;
    if (nb >= 0) begin
      // Field one, then time code, type word, bin width and payload
      raw(wf_pkg::WF_FIELD_ONE, 3'h0);
      for (int k = 2; k < 6; k++) raw(wf_pkg::wf_kind_t'(k), 3'h0);
      repeat (nb) begin
        raw(wf_pkg::WF_BLOCK_START, v);
        raw(wf_pkg::WF_BIN_WIDTH, 3'h0);
        if (p) raw(wf_pkg::WF_PAYLOAD, 3'h0);
      end
    end
    if (t) raw(wf_pkg::WF_FIELD_TWO, 3'h0);
    i_wf_link_if_b.h2d_valid = 1'h0;
    repeat (3) @(posedge core_clk);
    #1 n_checks++;
    if ((n_err2 != 0) != x) fail("framing error flag wrong");
    $display("test error case %0d %0d done", nb, v);
  endtask
  always @(posedge core_clk) begin
    if (dec_valid === 1'h1) chk(0, dec_tok);
    if (snk_valid === 1'h1 && snk_ready === 1'h1) chk(1, snk_tok);
    if (dec_valid === 1'h1 && dec_tok.kind == wf_pkg::WF_TYPE) begin
      n_checks++;
      if (dec_blk !== `WF_BLK_ZERO) fail("first block count wrong");
    end
    if (dec_err !== 1'h0) n_err++;
    if (dec_done === 1'h1) n_done++;
    if (err2 === 1'h1) n_err2++;
  end
  // ****************************************
  // Main sequence
  // ****************************************
  initial begin
    i_wf_link_if_b.h2d_valid = 1'h0;
    i_wf_link_if_b.h2d_tok = 38'h0;
    i_wf_link_if_b.d2h_ready = 1'h1;
    repeat (4) @(posedge core_clk);
    #1 rstn = 1'h1;
    n_checks++;
    if (i_wf_link_if.d2h_valid !== 1'h0) fail("valid after reset");
    fork
      run(0);
      run(1);
    join
    for (int k = 0; k < 500 && exq[0].size() + exq[1].size() > 0; k++)
      @(posedge core_clk);
    #1 n_checks += 2;
    if (exq[0].size() + exq[1].size() != 0) fail("tokens lost");
    if (n_done != 1 || n_err != 0) fail("done or error count");
    $display("test both directions done");
    err_case(-1, 3'h3, 1'h1, 1'h1, 1'h1);
    err_case(40, 3'h3, 1'h1, 1'h1, 1'h1);
    err_case(42, 3'h3, 1'h1, 1'h0, 1'h1);
    for (int v = 0; v < 8; v++)
      err_case(1, 3'(v), 1'h0, 1'h0, v == 0 || v > 5);
    err_case(1, 3'h5, 1'h1, 1'h0, 1'h1);
    err_case(41, 3'h5, 1'h0, 1'h1, 1'h0);
    wrap_up();
  end
endmodule // wavelet_field_bitstream_framer_bench

// ### test/wf_link_properties.sv
/* Checker of the link between the two framer ends: token order,
   block count, delimiter variants and hold of a stalled token.
   Assumes one clock domain; signals are wired by name. */
`timescale 1ns/1ps
`include "wf_cfg.svh"
module wf_link_properties (
  input wire logic core_clk,
  input wire logic rstn,
  input wire logic h2d_valid,
  input wire logic h2d_ready,
  input wire wf_pkg::wf_tok_t h2d_tok,
  input wire logic d2h_valid,
  input wire logic d2h_ready,
  input wire wf_pkg::wf_tok_t d2h_tok
);
  // ****************************************
  // History of accepted tokens
  // ****************************************
  logic h_acc;
  logic h_fld;
  logic [2:0] h_last_q;
  logic [2:0] d_last_q;
  logic h_fld_q;
  logic h_have_q;
  logic h_zero_q;
  logic [5:0] h_cnt_q;
  assign h_acc = h2d_valid && h2d_ready;
  assign h_fld = h2d_tok.kind[2:1] == 2'h0;
  // Reset to sequence end so no stale field steers the order checks
  always_ff @(posedge core_clk or negedge rstn) begin
    if (!rstn) begin
      h_last_q <= 3'h7;
      d_last_q <= 3'h7;
      h_fld_q <= 1'h0;
      h_have_q <= 1'h0;
      h_zero_q <= 1'h0;
      h_cnt_q <= 6'h00;
    end else begin
      if (h_acc) begin
        h_last_q <= h2d_tok.kind;
        h_have_q <= h_fld || (h_have_q && h2d_tok.kind != wf_pkg::WF_SEQ_END);
        h_cnt_q <= h_fld ? 6'h00 :
          h_cnt_q + {5'h00, h2d_tok.kind == wf_pkg::WF_BLOCK_START};
        if (h_fld) h_fld_q <= h2d_tok.kind[0];
        // A new field must not inherit the last block's zero flag
        if (h_fld) h_zero_q <= 1'h0;
        if (h2d_tok.kind == wf_pkg::WF_BLOCK_START) h_zero_q <=
          h2d_tok.variant == `WF_VAR_ZERO;
      end
      if (d2h_valid && d2h_ready) d_last_q <= d2h_tok.kind;
    end
  end
  // ****************************************
  // Properties
  // ****************************************
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rstn);
  a_field_alternates: assert property (
    h_acc && h_fld && h_have_q |-> h2d_tok.kind[0] != h_fld_q)
    else $error("field delimiters do not alternate");
  a_timecode_follows: assert property (
    h_acc && h_last_q[2:1] == 2'h0 |-> h2d_tok.kind == wf_pkg::WF_TIME_CODE)
    else $error("field not followed by time code");
  a_type_follows: assert property (
    h_acc && h_last_q == wf_pkg::WF_TIME_CODE |->
    h2d_tok.kind == wf_pkg::WF_TYPE && h2d_tok.data == `WF_TYPE_WORD)
    else $error("time code not followed by type word");
  a_width_after_type: assert property (
    d2h_valid && d_last_q == wf_pkg::WF_TYPE |->
    d2h_tok.kind == wf_pkg::WF_BIN_WIDTH)
    else $error("type word not followed by bin width");
  a_block_count: assert property (
    h_acc && h_have_q && (h_fld || h2d_tok.kind == wf_pkg::WF_SEQ_END)
    |-> h_cnt_q == `WF_BLOCKS)
    else $error("field closed with wrong block count");
  a_width_after_start: assert property (
    d2h_valid && d_last_q == wf_pkg::WF_BLOCK_START |->
    d2h_tok.kind == wf_pkg::WF_BIN_WIDTH)
    else $error("block start not followed by bin width");
  a_variant_legal: assert property (
    d2h_valid && d2h_tok.kind == wf_pkg::WF_BLOCK_START |->
    d2h_tok.variant inside {[`WF_VAR_MIN:`WF_VAR_ZERO]})
    else $error("block start variant out of range");
  a_zero_no_payload: assert property (
    h_acc && h_zero_q && h_last_q == wf_pkg::WF_BIN_WIDTH |->
    h2d_tok.kind != wf_pkg::WF_PAYLOAD)
    else $error("payload sent after zero block");
  a_token_holds: assert property (
    d2h_valid && !d2h_ready |=> d2h_valid && $stable(d2h_tok))
    else $error("stalled token changed");
  c_field_two: cover property (h_acc && h2d_tok.kind == wf_pkg::WF_FIELD_TWO);
  c_stall: cover property (d2h_valid && !d2h_ready);
  c_seq_end: cover property (h_acc && h2d_tok.kind == wf_pkg::WF_SEQ_END);
endmodule // wf_link_properties
